// ==== core/adfs_regs.svh ====
// Purpose: named constants of the acceleration decimate, filter and scale chain
// Assumes: 125 MHz core clock, 1 MHz modulator bit rate
// Notes: coefficients are Q3.13, the overall filter gain is in units of 2^-30
`ifndef ADFS_REGS_SVH
`define ADFS_REGS_SVH

// timing
`define ADFS_CLK_MHZ        125
`define ADFS_BIT_RATE_MHZ   1
`define ADFS_BIT_CYCLES     (`ADFS_CLK_MHZ / `ADFS_BIT_RATE_MHZ)
`define ADFS_DECIM          16
`define ADFS_SAMPLE_US      16
`define ADFS_ANSWER_DELAY   2
// interpolation: sixteen steps per sample, so the step product drops four bits
`define ADFS_INTERP_SHIFT   4

// sinc scaling: a full-scale sinc output lands on bit 21
`define ADFS_SINC_SHIFT     9
// filter fixed point
`define ADFS_COEF_FRAC      13
`define ADFS_GAIN_FRAC      30
`define ADFS_COEF_ONE       16'sh2000
`define ADFS_COEF_TWO       16'sh4000
`define ADFS_COEF_ZERO      16'sh0000
// denominators, section 1 and 2, per response; the 180 response has section 1 only
`define ADFS_LP180_D2       16'shC0D2
`define ADFS_LP180_D3       16'sh1F31
`define ADFS_LP400_S1_D2    16'shC257
`define ADFS_LP400_S1_D3    16'sh1DB5
`define ADFS_LP400_S2_D2    16'shC105
`define ADFS_LP400_S2_D3    16'sh1F08
`define ADFS_LP800_S1_D2    16'shC49D
`define ADFS_LP800_S1_D3    16'sh1B94
`define ADFS_LP800_S2_D2    16'shC21C
`define ADFS_LP800_S2_D3    16'sh1E17
// overall gains giving unity gain at DC
`define ADFS_LP180_GAIN     18'sh18000
`define ADFS_LP400_GAIN     18'sh0009C
`define ADFS_LP800_GAIN     18'sh009C3

// compensation fixed point
`define ADFS_COMP_FRAC      14
`define ADFS_QUAD_FRAC      21

// output field of the 26-bit result
`define ADFS_SIG_MSB        21
`define ADFS_SIG_MAX        26'sh01FFFFF
`define ADFS_SIG_MIN        26'sh3E00000
`define ADFS_W10_LSB        12
`define ADFS_W9_LSB         13
`define ADFS_W8_LSB         14
`define ADFS_MIN_CODE       10'h001
`define ADFS_ZERO_CODE      10'h000

`endif

// ==== core/adfs_pkg.sv ====
// Purpose: types of the acceleration decimate, filter and scale chain
// Assumes: nothing
// Notes: constants live in adfs_regs.svh
package adfs_pkg;
	// low-pass response choice; the fourth code is not a valid setting
	typedef enum logic [1:0] {ADFS_LP_180, ADFS_LP_400, ADFS_LP_800, ADFS_LP_RSVD} adfs_lpsel_t;
	// answer word width
	typedef enum logic [1:0] {ADFS_W10, ADFS_W9, ADFS_W8} adfs_width_t;
endpackage

// ==== core/adfs_sinc3.sv ====
// Purpose: third-order sinc decimator, 16 bits in, one parallel sample out
// Assumes: bitTick marks each modulator bit, bitIn already synchronised
// Notes: integrators wrap on purpose; the comb stages undo the wrap
`timescale 1ns/10ps
`default_nettype none
`include "adfs_regs.svh"
module adfs_sinc3 (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// bitstream
	input  wire logic               bitTick,
	input  wire logic               bitIn,
	// decimated sample
	output logic signed [25:0]      sampleOut,
	output logic                    sampleValid,
	output logic        [3:0]       phase
);
	logic signed [15:0] integ1, integ2, integ3;   // running sums
	logic signed [15:0] comb1, comb2, comb3;      // comb delays at sample rate
	logic signed [15:0] diff1, diff2, diff3;      // comb outputs

	// comb differences, read only on the decimation edge
	always_comb
	begin
		diff1 = integ3 - comb1;
		diff2 = diff1 - comb2;
		diff3 = diff2 - comb3;
	end

	// integrators: a one bit counts +1, a zero bit counts -1
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			integ1 <= 16'sh0000;
			integ2 <= 16'sh0000;
			integ3 <= 16'sh0000;
			phase  <= 4'h0;
		end
		else if (bitTick)
		begin
			integ1 <= integ1 + (bitIn ? 16'sh0001 : 16'shFFFF);
			integ2 <= integ2 + integ1;
			integ3 <= integ3 + integ2;
			phase  <= phase + 4'h1;
		end
	end

	// decimate by 16; the gain of 16 per stage is kept and the left shift moves full scale up to bit 21
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			comb1       <= 16'sh0000;
			comb2       <= 16'sh0000;
			comb3       <= 16'sh0000;
			sampleOut   <= 26'sh0000000;
			sampleValid <= 1'b0;
		end
		else
		begin
			sampleValid <= 1'b0;
			if (bitTick && phase == 4'(`ADFS_DECIM - 1))
			begin
				comb1       <= integ3;
				comb2       <= diff1;
				comb3       <= diff2;
				sampleOut   <= {{10{diff3[15]}}, diff3} <<< `ADFS_SINC_SHIFT;
				sampleValid <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== core/adfs_chain.sv ====
// Purpose: acceleration chain: sinc decimation, IIR low-pass, compensation,
//          one-sample delay, 16-step interpolation, clip and truncation
// Assumes: modulator bit is asynchronous; request strobe is on clk
// Notes: filter runs once per 16 us sample, a few clocks after decimation
`timescale 1ns/10ps
`default_nettype none
`include "adfs_regs.svh"
module adfs_chain (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// modulator
	input  wire logic                  sdBit,
	// configuration and trim
	input  wire adfs_pkg::adfs_lpsel_t lowpassSelect,
	input  wire adfs_pkg::adfs_width_t outWidth,
	input  wire logic signed [25:0]    compOffset,
	input  wire logic signed [15:0]    compGain,
	input  wire logic signed [15:0]    compNonlin,
	// request and answer
	input  wire logic                  reqStrobe,
	output logic             [9:0]     accelWord,
	output logic                       accelValid
);
	logic               sdMeta, sdSync;         // bit synchroniser
	logic        [6:0]  bitCount;               // cycles within one bit
	logic               bitTick;                // one per modulator bit
	logic signed [25:0] sincOut;
	logic               sincValid;
	logic        [3:0]  sincPhase;              // bits since last sample
	logic signed [63:0] sx1 [2], sx2 [2], sy1 [2], sy2 [2]; // section histories
	logic signed [63:0] s1Out, s2Out, gIn, next_s1, next_s2;
	logic               s1Valid, s2Valid, compValid;
	logic signed [25:0] compOut, next_comp;
	logic signed [25:0] prevSample, curSample;  // the two stored samples
	logic signed [25:0] capt;                   // interpolated capture
	logic               captValid;
	adfs_pkg::adfs_width_t captWidth;

	// filter coefficient: k 0..2 numerator, 3..4 denominator
	function automatic logic signed [15:0] coefOf(input adfs_pkg::adfs_lpsel_t sel,
		input logic sec, input logic [2:0] k);
		logic signed [15:0] d2, d3;
		logic               bypass;
		bypass = 1'b0;
		case (sel)
			adfs_pkg::ADFS_LP_400:
			begin
				d2 = sec ? `ADFS_LP400_S2_D2 : `ADFS_LP400_S1_D2;
				d3 = sec ? `ADFS_LP400_S2_D3 : `ADFS_LP400_S1_D3;
			end
			adfs_pkg::ADFS_LP_800:
			begin
				d2 = sec ? `ADFS_LP800_S2_D2 : `ADFS_LP800_S1_D2;
				d3 = sec ? `ADFS_LP800_S2_D3 : `ADFS_LP800_S1_D3;
			end
			default:
			begin
				// two-pole response; the unused code falls here as well
				bypass = sec;
				d2 = sec ? `ADFS_COEF_ZERO : `ADFS_LP180_D2;
				d3 = sec ? `ADFS_COEF_ZERO : `ADFS_LP180_D3;
			end
		endcase
		case (k)
			3'h0:    return `ADFS_COEF_ONE;
			3'h1:    return bypass ? `ADFS_COEF_ZERO : `ADFS_COEF_TWO;
			3'h2:    return bypass ? `ADFS_COEF_ZERO : `ADFS_COEF_ONE;
			3'h3:    return d2;
			default: return d3;
		endcase
	endfunction

	// overall gain, applied ahead of both sections
	function automatic logic signed [17:0] gainOf(input adfs_pkg::adfs_lpsel_t sel);
		case (sel)
			adfs_pkg::ADFS_LP_400: return `ADFS_LP400_GAIN;
			adfs_pkg::ADFS_LP_800: return `ADFS_LP800_GAIN;
			default:               return `ADFS_LP180_GAIN;
		endcase
	endfunction

	// direct-form second-order section, leading denominator is one
	function automatic logic signed [63:0] biquad(input logic signed [63:0] x,
		input logic signed [63:0] x1, input logic signed [63:0] x2,
		input logic signed [63:0] y1, input logic signed [63:0] y2,
		input adfs_pkg::adfs_lpsel_t sel, input logic sec);
		logic signed [79:0] acc;
		acc = coefOf(sel, sec, 3'h0) * x + coefOf(sel, sec, 3'h1) * x1
			+ coefOf(sel, sec, 3'h2) * x2 - coefOf(sel, sec, 3'h3) * y1
			- coefOf(sel, sec, 3'h4) * y2;
		acc = acc >>> `ADFS_COEF_FRAC;
		return acc[63:0];
	endfunction

	// modulator bit crosses in through two flip-flops
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sdMeta <= 1'b0;
			sdSync <= 1'b0;
		end
		else
		begin
			sdMeta <= sdBit;
			sdSync <= sdMeta;
		end
	end

	// 1 MHz bit clock from the core clock
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bitCount <= 7'h00;
			bitTick  <= 1'b0;
		end
		else
		begin
			bitTick  <= (bitCount == 7'(`ADFS_BIT_CYCLES - 1));
			bitCount <= bitTick ? 7'h01 : bitCount + 7'h01;
		end
	end

	adfs_sinc3 u_sinc (
		.clk         (clk),
		.rst         (rst),
		.bitTick     (bitTick),
		.bitIn       (sdSync),
		.sampleOut   (sincOut),
		.sampleValid (sincValid),
		.phase       (sincPhase)
	);

	// gain first, then the two sections; wide state keeps the gain's fraction
	always_comb
	begin
		gIn     = 64'(sincOut * gainOf(lowpassSelect));
		next_s1 = biquad(gIn, sx1[0], sx2[0], sy1[0], sy2[0], lowpassSelect, 1'b0);
		next_s2 = biquad(s1Out, sx1[1], sx2[1], sy1[1], sy2[1], lowpassSelect, 1'b1);
	end

	// section updates, one clock apart after each decimated sample
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < 2; i++)
			begin
				sx1[i] <= 64'sh0;
				sx2[i] <= 64'sh0;
				sy1[i] <= 64'sh0;
				sy2[i] <= 64'sh0;
			end
			s1Out   <= 64'sh0;
			s2Out   <= 64'sh0;
			s1Valid <= 1'b0;
			s2Valid <= 1'b0;
		end
		else
		begin
			s1Valid <= sincValid;
			s2Valid <= s1Valid;
			if (sincValid)
			begin
				sx2[0] <= sx1[0];
				sx1[0] <= gIn;
				sy2[0] <= sy1[0];
				sy1[0] <= next_s1;
				s1Out  <= next_s1;
			end
			if (s1Valid)
			begin
				sx2[1] <= sx1[1];
				sx1[1] <= s1Out;
				sy2[1] <= sy1[1];
				sy1[1] <= next_s2;
				s2Out  <= next_s2;
			end
		end
	end

	// offset, sensitivity (Q2.14) and square-law correction
	always_comb
	begin
		logic signed [63:0] y, lin, sens, quad, corr;
		y         = s2Out >>> `ADFS_GAIN_FRAC;
		lin       = y - compOffset;
		sens      = (lin * compGain) >>> `ADFS_COMP_FRAC;
		quad      = (sens * sens) >>> `ADFS_QUAD_FRAC;
		corr      = sens + ((quad * compNonlin) >>> `ADFS_COMP_FRAC);
		next_comp = corr[25:0];
	end

	// compensated result, then the one-sample hold-back
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			compOut    <= 26'sh0;
			compValid  <= 1'b0;
			prevSample <= 26'sh0;
			curSample  <= 26'sh0;
		end
		else
		begin
			compValid <= s2Valid;
			if (s2Valid)
				compOut <= next_comp;
			if (compValid)
			begin
				prevSample <= curSample;
				curSample  <= compOut;
			end
		end
	end

	// capture on request: prev + (cur - prev) * step / 16
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			capt      <= 26'sh0;
			captValid <= 1'b0;
			captWidth <= adfs_pkg::ADFS_W10;
		end
		else
		begin
			captValid <= reqStrobe;
			if (reqStrobe)
			begin
				// widened first: a headroom-size step times fifteen overflows 26 bits
				capt      <= 26'(32'(prevSample) + ((32'(curSample) - 32'(prevSample))
					* 32'($signed({1'b0, sincPhase})) >>> `ADFS_INTERP_SHIFT));
				captWidth <= outWidth;
			end
		end
	end

	// clip to the signal field, offset-binary, truncate to the chosen width
	function automatic logic [9:0] scaleWord(input logic signed [25:0] v,
		input adfs_pkg::adfs_width_t w);
		logic signed [25:0] c;
		logic        [21:0] f;
		logic        [9:0]  word;
		c = v;
		if (v > `ADFS_SIG_MAX) c = `ADFS_SIG_MAX;
		if (v < `ADFS_SIG_MIN) c = `ADFS_SIG_MIN;
		f = {~c[`ADFS_SIG_MSB], c[`ADFS_SIG_MSB-1:0]};
		case (w)
			adfs_pkg::ADFS_W9: word = {1'b0, f[`ADFS_SIG_MSB:`ADFS_W9_LSB]};
			adfs_pkg::ADFS_W8: word = {2'b00, f[`ADFS_SIG_MSB:`ADFS_W8_LSB]};
			default:           word = f[`ADFS_SIG_MSB:`ADFS_W10_LSB];
		endcase
		if (w != adfs_pkg::ADFS_W10 && word == `ADFS_ZERO_CODE)
			word = `ADFS_MIN_CODE;
		return word;
	endfunction

	// answer: the word stands and stays flagged until the next request
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			accelWord  <= 10'h000;
			accelValid <= 1'b0;
		end
		else if (captValid)
		begin
			accelWord  <= scaleWord(capt, captWidth);
			accelValid <= 1'b1;
		end
		else if (reqStrobe)
			accelValid <= 1'b0;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence seqFilter;
		sincValid ##1 s1Valid ##1 s2Valid;
	endsequence
	sequence seqAnswer;
		##1 captValid ##1 accelValid;
	endsequence

	AST_BIT_SPACING: assert property (bitTick |=> !bitTick [*8])
		else $error("modulator bit ticks too close");
	AST_DECIM_PHASE: assert property (sincValid |-> sincPhase == 4'h0)
		else $error("sample not on a 16-bit boundary");
	AST_FILTER_ORDER: assert property (sincValid |-> seqFilter ##1 compValid)
		else $error("filter stages out of order");
	AST_TWO_POLE: assert property (s2Valid && lowpassSelect == adfs_pkg::ADFS_LP_180
		&& $stable(lowpassSelect) |-> s2Out == $past(s1Out))
		else $error("two-pole response not bypassing section two");
	AST_HOLD_BACK: assert property (compValid |=> curSample == $past(compOut)
		&& prevSample == $past(curSample))
		else $error("sample hold-back wrong");
	AST_ANSWER_TIME: assert property (reqStrobe |-> seqAnswer)
		else $error("answer not two clocks after request");
	AST_NO_ZERO: assert property (accelValid && $rose(accelValid)
		&& $past(captWidth) != adfs_pkg::ADFS_W10 |-> accelWord != 10'h000)
		else $error("zero code sent on short word");
	AST_SAT_HIGH: assert property (captValid && capt > `ADFS_SIG_MAX
		&& captWidth == adfs_pkg::ADFS_W10 |=> accelWord == 10'h3FF)
		else $error("positive overrange did not saturate");
	AST_INTERP_BOUND: assert property (captValid && $past(prevSample) <= $past(curSample)
		|-> capt >= $past(prevSample) && capt <= $past(curSample))
		else $error("interpolation outside the two samples");
endmodule
`default_nettype wire

// ==== verif/adfs_mod_model.sv ====
// Purpose: modulator stand-in that feeds the chain one bit every 125 clocks
// Assumes: shares clk and rst with the chain under test
// Notes: alternating bits average to exactly zero, all ones is positive full scale
`timescale 1ns/10ps
`default_nettype none
module adfs_mod_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// pattern choice and bitstream
	input  wire logic allOnes,
	output var logic  sdBit
);
	logic [6:0] bitCount; // clocks spent in the current bit
	logic       toggle;   // state of the zero-mean square wave

	// a new bit each 125 clocks, held steady in between like the real converter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bitCount <= 7'h00;
			toggle   <= 1'b0;
		end
		else if (bitCount == 7'h7C)
		begin
			bitCount <= 7'h00;
			toggle   <= ~toggle;
		end
		else
		begin
			bitCount <= bitCount + 7'h01;
		end
	end

	// ones mode gives a full-scale step; a square wave keeps every window at zero
	always_comb
	begin
		sdBit = allOnes | toggle;
	end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench of the acceleration chain
// Assumes: zero-mean input in the table cases, so their answers are set by the trim inputs alone
// Notes: expected words carry half an LSB of margin against filter ringing
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// one ordinary case: settings beside the word they should give
	typedef struct packed
	{
		adfs_pkg::adfs_lpsel_t sel;
		adfs_pkg::adfs_width_t wid;
		logic [25:0]           off;
		logic [15:0]           gain;
		logic [15:0]           nl;
		logic [9:0]            expVal;
	} adfs_row_t;

	localparam adfs_pkg::adfs_lpsel_t lp1 = adfs_pkg::ADFS_LP_180;
	localparam adfs_pkg::adfs_lpsel_t lp4 = adfs_pkg::ADFS_LP_400;
	localparam adfs_pkg::adfs_lpsel_t lp8 = adfs_pkg::ADFS_LP_800;
	localparam adfs_pkg::adfs_width_t w10 = adfs_pkg::ADFS_W10;
	localparam adfs_pkg::adfs_width_t w9  = adfs_pkg::ADFS_W9;
	localparam adfs_pkg::adfs_width_t w8  = adfs_pkg::ADFS_W8;

	adfs_row_t             rows [11];     // case table
	logic                  clk;           // 125 MHz core clock
	logic                  rst;           // async reset, active high
	logic                  sdBit;         // modulator bit
	logic                  allOnes;       // modulator pattern choice
	logic                  reqStrobe;     // data request pulse
	logic                  accelValid;    // answer flag
	adfs_pkg::adfs_lpsel_t lowpassSelect; // filter response
	adfs_pkg::adfs_width_t outWidth;      // answer width
	logic signed [25:0]    compOffset;    // offset trim
	logic signed [15:0]    compGain;      // sensitivity trim
	logic signed [15:0]    compNonlin;    // square-law trim
	logic [9:0]            accelWord;     // answer word
	logic [9:0]            wordA;         // first captured word
	logic [9:0]            wordB;         // second captured word
	int                    numErrors;     // mismatches
	int                    compares;      // comparisons made

	adfs_mod_model modU (.clk(clk), .rst(rst), .allOnes(allOnes), .sdBit(sdBit));

	adfs_chain dut_u (
		.clk(clk), .rst(rst), .sdBit(sdBit), .lowpassSelect(lowpassSelect),
		.outWidth(outWidth), .compOffset(compOffset), .compGain(compGain),
		.compNonlin(compNonlin), .reqStrobe(reqStrobe), .accelWord(accelWord),
		.accelValid(accelValid)
	);

	// free-running clock, 8 ns period
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// compare and count; four-state equality so an unknown never matches
	task automatic check(input string name, input logic [9:0] seen, input logic [9:0] expVal);
		compares++;
		if (seen !== expVal)
		begin
			numErrors++;
			$display("Error %s expected %h seen %h", name, expVal, seen);
		end
	endtask

	// one-cycle strobe, then the flag must drop and rise on fixed edges
	task automatic request(output logic [9:0] word);
		@(posedge clk) #1 reqStrobe = 1'b1;
		@(posedge clk) #1 reqStrobe = 1'b0;
		// the taking edge has just passed: the old flag is down, the capture is pending
		check("valid drop", {9'h000, accelValid}, 10'h000);
		@(posedge clk) #1 check("valid rise", {9'h000, accelValid}, 10'h001);
		word = accelWord;
	endtask

	// single exit point of the run
	task automatic endOfTest();
		$display("Comparisons %0d, mismatches %0d", compares, numErrors);
		if (numErrors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// watchdog: the sequence needs about 81k cycles, so 95k means a hang
	initial
	begin
		#(8 * 95000);
		numErrors++;
		endOfTest();
	end

	// main sequence
	initial
	begin
		numErrors     = 0;
		compares      = 0;
		rst           = 1'b1;
		allOnes       = 1'b0;
		reqStrobe     = 1'b0;
		lowpassSelect = lp8;
		outWidth      = w10;
		compOffset    = 26'h3FFF800;
		compGain      = 16'h4000;
		compNonlin    = 16'h0000;
		// offsets sit half an LSB inside a code so small ringing cannot flip it
		rows[0]  = '{lp8, w10, 26'h3FFF800, 16'h4000, 16'h0000, 10'h200};
		rows[1]  = '{lp8, w9,  26'h3FFF800, 16'h4000, 16'h0000, 10'h100};
		rows[2]  = '{lp8, w8,  26'h3FFF800, 16'h4000, 16'h0000, 10'h080};
		rows[3]  = '{lp4, w10, 26'h3EFF800, 16'h4000, 16'h0000, 10'h300};
		rows[4]  = '{lp1, w9,  26'h3EFF800, 16'h4000, 16'h0000, 10'h180};
		rows[5]  = '{lp8, w8,  26'h3EFF800, 16'h2000, 16'h0000, 10'h0A0};
		// square law: 0x100400 + (0x100400^2 >> 21) = 0x180800, half an LSB inside
		rows[6]  = '{lp8, w10, 26'h3EFFC00, 16'h4000, 16'h4000, 10'h380};
		rows[7]  = '{lp8, w10, 26'h3C00000, 16'h4000, 16'h0000, 10'h3FF};
		rows[8]  = '{lp8, w10, 26'h0400000, 16'h4000, 16'h0000, 10'h000};
		rows[9]  = '{lp8, w9,  26'h0400000, 16'h4000, 16'h0000, 10'h001};
		rows[10] = '{lp8, w8,  26'h0400000, 16'h4000, 16'h0000, 10'h001};
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		// table cases; each waits two samples so both stored samples are fresh
		for (int i = 0; i < 11; i++)
		begin
			lowpassSelect = rows[i].sel;
			outWidth      = rows[i].wid;
			compOffset    = rows[i].off;
			compGain      = rows[i].gain;
			compNonlin    = rows[i].nl;
			repeat (4200) @(posedge clk);
			#1;
			request(wordA);
			check("table word", wordA, rows[i].expVal);
		end
		// reset in mid-run clears the answer
		@(posedge clk) #1 rst = 1'b1;
		@(posedge clk) #1 check("reset word", accelWord, 10'h000);
		check("reset valid", {9'h000, accelValid}, 10'h000);
		@(posedge clk) #1 rst = 1'b0;
		// full-scale step: nothing may show before a sample has passed the delay
		lowpassSelect = lp8;
		outWidth      = w10;
		compOffset    = 26'h3FFF800;
		allOnes       = 1'b1;
		repeat (1000) @(posedge clk);
		#1;
		request(wordA);
		check("early word", wordA, 10'h200);
		// later the step has crossed decimation and filter and keeps climbing
		repeat (30000) @(posedge clk);
		#1;
		request(wordA);
		check("ramp started", {9'h000, wordA > 10'h202}, 10'h001);
		repeat (4000) @(posedge clk);
		#1;
		request(wordB);
		check("ramp rising", {9'h000, wordB > wordA}, 10'h001);
		endOfTest();
	end
endmodule
`default_nettype wire
